// ### ccd_afe_tg_control_registers.sv
`timescale 1ns/1ps
// Functional notes
// - Wide registers span two addresses, low first
// - Default update at field/line sync boundary
// - Listed control registers apply at latch rise
// - Substrate settings apply after sensor-gate line
// - Soft reset bit restores all defaults
// - Output enable low forces inactive outputs, except clocksSuspended
// - Update line selects sync update line
// - Freeze bit blocks sync-class updates
// - Readback bit enables serial register readback
// - Data clock source selects phase or oscillator
// - Halver bit divides master clock by two
// - Field preset sets next field parity
// - Retime bits resync blanking per phase pair
// - External sync enable, polarity, clock suspend
// - Shared pin selects field/line, clamp/blank
// - Timing core held reset while run low
// - Frame transfer turns gates into vertical clocks
// - Shared clamp makes dummy equal black clamp
// - Output delay code none/4/8/12 ns
// - Oscillator run low powers oscillator down
// - Write is 10-bit address, 6-bit data, LSB first
// - Fewer than six data bits discards write
// - Further words go to next higher address
// - Upper-only write still updates full register
module ccd_afe_tg_control_registers (
	input  wire logic       clk_sys,
	input  wire logic       rst_b,
	input  wire logic       clkEn,
	input  wire logic       serialClock,          // Serial clock pin
	input  wire logic       serialDataIn,         // Serial data pin, input side
	input  wire logic       serial_latch_strobe,  // Latch strobe pin, low frames a write
	input  wire logic       vertical_drive_pulse, // Field sync pin, falling edge active
	input  wire logic       line_sync_pulse,      // Line sync pin, falling edge active
	input  wire logic       sensor_gate_pulse,    // Sensor gate pin, high marks gate line
	input  wire logic       extSyncIn,            // External sync pin
	input  wire logic       master_clock_input,   // Master clock pin
	input  wire logic       phaseClock,           // Programmed output phase clock
	input  wire logic       line_indicator,       // Timing core line pulse
	input  wire logic       black_level_clamp_pulse,
	input  wire logic       output_blanking,
	input  wire logic       dummy_clamp_pulse,
	input  wire logic       horizontal_blanking,
	input  wire logic       hClock1,              // Internal phase one clock
	input  wire logic       hClock3,              // Internal phase three clock
	output logic            serialDataOut,        // Serial data pin, output side
	output logic            serialDataOe,         // High while driving readback
	output logic [7:0]      afe_operation_mode,
	output logic [9:0]      vga_gain,
	output logic [7:0]      black_level,
	output logic [5:0]      afe_control_bits,
	output logic [5:0]      color0Gain,
	output logic [5:0]      color1Gain,
	output logic [5:0]      color2Gain,
	output logic [5:0]      color3Gain,
	output logic [5:0]      output_phase_select,
	output logic            input_restore_disable,
	output logic            tgCoreReset_b,
	output logic            frame_transfer_select,
	output logic [1:0]      output_data_delay,
	output logic            oscillator_run,
	output logic            internalClockTick,
	output logic            pixel_data_clock,
	output logic            sharedLineFieldPin,
	output logic            sharedClampBlankPin,
	output logic            dummyClampOut,
	output logic            blanking12,
	output logic            blanking34,
	output logic            clocksSuspended,
	output logic            sgLineUpdate          // One-cycle pulse, SG-class apply
);
	typedef enum logic [1:0] {
		SER_ADDR = 2'b00,
		SER_DATA = 2'b01
	} serState_t;

	localparam int PINS = 8;
	logic [PINS-1:0] pinMeta;                // First synchroniser stage only
	logic [PINS-1:0] pinSync;                // Second stage, safe to read
	logic [PINS-1:0] pinLast;                // Previous synced value for edges
	logic [5:0]      shadow [0:63];          // Serially written values
	logic [5:0]      active [0:63];          // Values the device uses
	logic [63:0]     pending;                // Slot waits for its update event
	serState_t       serState;
	logic [3:0]      bitCount;
	logic [9:0]      addrShift;
	logic [5:0]      dataShift;
	logic [9:0]      wrAddr;                 // Auto-incrementing target
	logic [11:0]     lineCount;              // Lines since last field sync
	logic            fieldNextEven;
	logic            fieldIndicator;
	logic            sgArmed;
	logic            halfTick;

	// Synced pin views
	wire sclkS  = pinSync[0];
	wire sdataS = pinSync[1];
	wire ltS    = pinSync[2];
	wire fsS    = pinSync[3];
	wire lsS    = pinSync[4];
	wire gateS  = pinSync[5];
	wire syncS  = pinSync[6];
	wire mclkS  = pinSync[7];
	wire sclkRise = sclkS & ~pinLast[0];
	wire sclkFall = ~sclkS & pinLast[0];
	wire ltRise   = ltS & ~pinLast[2];
	wire fsFall   = ~fsS & pinLast[3];
	wire lsFall   = ~lsS & pinLast[4];
	wire gateRise = gateS & ~pinLast[5];

	// Decode of the serial engine
	wire [5:0]  wrIdx      = wrAddr[5:0];
	wire        wrMapped   = (wrAddr[9:6] == 4'h0);
	wire        readMode   = active[ccd_afe_tg_pkg::A_READBACK][0];
	wire        dataLast   = (bitCount == ccd_afe_tg_pkg::DATA_CNT);
	wire        addrLast   = (bitCount == ccd_afe_tg_pkg::ADDR_CNT);
	wire [5:0]  nextData   = {sdataS, dataShift[5:1]};
	wire        wordDone   = ~ltS & sclkRise & (serState == SER_DATA) & dataLast;
	wire        wordWrite  = wordDone & wrMapped & ~readMode;
	wire        pairHigh   = ccd_afe_tg_pkg::isPairLow(wrIdx - 6'h01);
	wire [5:0]  pairLowIdx = wrIdx - 6'h01;

	// Update events
	wire [11:0] updateLine = {active[ccd_afe_tg_pkg::A_UPD_HI], active[ccd_afe_tg_pkg::A_UPD_LO]};
	wire        freeze     = active[ccd_afe_tg_pkg::A_FREEZE][0];
	wire        syncApply  = lsFall & (lineCount == updateLine) & ~freeze;
	wire        softReset  = ltRise & pending[ccd_afe_tg_pkg::A_SOFT_RST]
		& shadow[ccd_afe_tg_pkg::A_SOFT_RST][0];
	wire        fieldPreset = ltRise & pending[ccd_afe_tg_pkg::A_FIELD];

	// Effective control bits
	wire outEn     = active[ccd_afe_tg_pkg::A_OUT_EN][0];
	wire syncLevel = active[ccd_afe_tg_pkg::A_SYNC_POL][0] ? syncS : ~syncS;
	wire syncAct   = active[ccd_afe_tg_pkg::A_SYNC_EN][0] & syncLevel;
	wire pdcNext   = active[ccd_afe_tg_pkg::A_PIXCLK_SRC][0] ? ~mclkS : phaseClock;
	wire lfNext    = active[ccd_afe_tg_pkg::A_LF_SEL][0] ? line_indicator : fieldIndicator;
	wire cbNext    = active[ccd_afe_tg_pkg::A_CB_SEL][0] ? output_blanking
		: black_level_clamp_pulse;
	wire dmNext    = active[ccd_afe_tg_pkg::A_SHARED][0] ? black_level_clamp_pulse
		: dummy_clamp_pulse;

	// Two-stage synchronisers on every pin input
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pinMeta <= 8'h1c; // Idle pin levels, so no false edge after reset
			pinSync <= 8'h1c;
			pinLast <= 8'h1c;
		end
		else if (clkEn)
		begin
			pinMeta <= {master_clock_input, extSyncIn, sensor_gate_pulse, line_sync_pulse,
				vertical_drive_pulse, serial_latch_strobe, serialDataIn, serialClock};
			pinSync <= pinMeta;
			pinLast <= pinSync;
		end
	end

	// Serial shift engine; strobe high drops any partial word
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			serState  <= SER_ADDR;
			bitCount  <= 4'h0;
			addrShift <= 10'h000;
			dataShift <= 6'h00;
			wrAddr    <= 10'h000;
		end
		else if (clkEn)
		begin
			if (ltS)
			begin
				serState <= SER_ADDR;
				bitCount <= 4'h0;
			end
			else if (sclkRise && serState == SER_ADDR)
			begin
				addrShift <= {sdataS, addrShift[9:1]};
				bitCount  <= addrLast ? 4'h0 : bitCount + 4'h1;
				if (addrLast)
				begin
					serState <= SER_DATA;
					wrAddr   <= {sdataS, addrShift[9:1]};
				end
			end
			else if (sclkRise)
			begin
				dataShift <= nextData;
				bitCount  <= dataLast ? 4'h0 : bitCount + 4'h1;
				if (dataLast)
					wrAddr <= wrAddr + 10'h001;
			end
		end
	end

	// Readback drives the data pin on falling serial clock
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			serialDataOut <= 1'b0;
			serialDataOe  <= 1'b0;
		end
		else if (clkEn)
		begin
			if (ltS || !readMode || serState != SER_DATA || !wrMapped)
				serialDataOe <= 1'b0;
			else if (sclkFall)
			begin
				serialDataOut <= active[wrIdx][bitCount[2:0]];
				serialDataOe  <= 1'b1;
			end
		end
	end

	// Shadow, pending and active register arrays
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			for (int i = 0; i < 64; i++)
			begin
				shadow[i] <= ccd_afe_tg_pkg::regDefault(6'(i));
				active[i] <= ccd_afe_tg_pkg::regDefault(6'(i));
			end
			pending <= 64'h0000_0000_0000_0000;
		end
		else if (clkEn)
		begin
			if (softReset)
			begin
				for (int i = 0; i < 64; i++)
				begin
					shadow[i] <= ccd_afe_tg_pkg::regDefault(6'(i));
					active[i] <= ccd_afe_tg_pkg::regDefault(6'(i));
				end
				pending <= 64'h0000_0000_0000_0000;
			end
			else
			begin
				for (int i = 0; i < 64; i++)
				begin
					// Latch class on strobe rise, others at the sync line
					if (pending[i] && ccd_afe_tg_pkg::isLatchClass(6'(i)) && ltRise)
					begin
						active[i]  <= shadow[i];
						pending[i] <= 1'b0;
					end
					else if (pending[i] && !ccd_afe_tg_pkg::isLatchClass(6'(i)) && syncApply)
					begin
						active[i]  <= shadow[i];
						pending[i] <= 1'b0;
					end
				end
				// Placed last so a fresh write stays pending over an apply
				if (wordWrite)
				begin
					shadow[wrIdx] <= nextData;
					if (!ccd_afe_tg_pkg::isPairLow(wrIdx))
						pending[wrIdx] <= 1'b1;
					if (pairHigh)
						pending[pairLowIdx] <= 1'b1;
				end
			end
		end
	end

	// Line counter, field parity and gate-line arming
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			lineCount      <= 12'h000;
			fieldNextEven  <= 1'b1;
			fieldIndicator <= 1'b0;
			sgArmed        <= 1'b0;
			sgLineUpdate   <= 1'b0;
		end
		else if (clkEn)
		begin
			if (fsFall)
				lineCount <= 12'h000;
			else if (lsFall)
				lineCount <= lineCount + 12'h001;
			if (softReset)
				fieldNextEven <= 1'b1;
			else if (fieldPreset)
				fieldNextEven <= shadow[ccd_afe_tg_pkg::A_FIELD][0];
			else if (fsFall)
				fieldNextEven <= ~fieldNextEven;
			if (fsFall)
				fieldIndicator <= fieldNextEven;
			// Arm wins over the consuming line edge
			sgArmed      <= gateRise | (sgArmed & ~lsFall);
			sgLineUpdate <= sgArmed & lsFall & ~gateS;
		end
	end

	// Clock divider for the internal clock enable
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			halfTick          <= 1'b0;
			internalClockTick <= 1'b0;
		end
		else if (clkEn)
		begin
			halfTick          <= ~halfTick;
			internalClockTick <= active[ccd_afe_tg_pkg::A_HALVER][0] ? halfTick : 1'b1;
		end
	end

	// Register fields onto flopped outputs
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			afe_operation_mode    <= 8'h10;
			vga_gain              <= 10'h045;
			black_level           <= 8'h80;
			afe_control_bits      <= 6'h00;
			color0Gain            <= 6'h00;
			color1Gain            <= 6'h00;
			color2Gain            <= 6'h00;
			color3Gain            <= 6'h00;
			output_phase_select   <= 6'h00;
			input_restore_disable <= 1'b0;
			tgCoreReset_b         <= 1'b0;
			frame_transfer_select <= 1'b0;
			output_data_delay     <= 2'h2;
			oscillator_run        <= 1'b1;
		end
		else if (clkEn)
		begin
			afe_operation_mode    <= {active[ccd_afe_tg_pkg::A_MODE_HI][1:0],
				active[ccd_afe_tg_pkg::A_MODE_LO]};
			vga_gain              <= {active[ccd_afe_tg_pkg::A_GAIN_HI][3:0],
				active[ccd_afe_tg_pkg::A_GAIN_LO]};
			black_level           <= {active[ccd_afe_tg_pkg::A_BLACK_HI][1:0],
				active[ccd_afe_tg_pkg::A_BLACK_LO]};
			afe_control_bits      <= active[ccd_afe_tg_pkg::A_CTRL];
			color0Gain            <= active[ccd_afe_tg_pkg::A_COLOR0];
			color1Gain            <= active[ccd_afe_tg_pkg::A_COLOR1];
			color2Gain            <= active[ccd_afe_tg_pkg::A_COLOR2];
			color3Gain            <= active[ccd_afe_tg_pkg::A_COLOR3];
			output_phase_select   <= active[ccd_afe_tg_pkg::A_PHASE];
			input_restore_disable <= active[ccd_afe_tg_pkg::A_RESTORE][0];
			tgCoreReset_b         <= active[ccd_afe_tg_pkg::A_TG_RUN][0];
			frame_transfer_select <= active[ccd_afe_tg_pkg::A_FTRANS][0];
			output_data_delay     <= active[ccd_afe_tg_pkg::A_DELAY][1:0];
			oscillator_run        <= active[ccd_afe_tg_pkg::A_OSC][0];
		end
	end

	// Timing pins, all but clocksSuspended forced low while outputs are disabled
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pixel_data_clock    <= 1'b0;
			sharedLineFieldPin  <= 1'b0;
			sharedClampBlankPin <= 1'b0;
			dummyClampOut       <= 1'b0;
			blanking12          <= 1'b0;
			blanking34          <= 1'b0;
			clocksSuspended     <= 1'b0;
		end
		else if (clkEn)
		begin
			pixel_data_clock    <= outEn & pdcNext;
			sharedLineFieldPin  <= outEn & lfNext;
			sharedClampBlankPin <= outEn & cbNext;
			dummyClampOut       <= outEn & dmNext;
			// Retimed copies only move on their phase clock
			if (!active[ccd_afe_tg_pkg::A_RETIME12][0] || hClock1)
				blanking12 <= outEn & horizontal_blanking;
			if (!active[ccd_afe_tg_pkg::A_RETIME34][0] || hClock3)
				blanking34 <= outEn & horizontal_blanking;
			clocksSuspended <= syncAct & active[ccd_afe_tg_pkg::A_SYNC_HOLD][0];
		end
	end
endmodule // ccd_afe_tg_control_registers

// ### ccd_afe_tg_pkg.sv
package ccd_afe_tg_pkg;
	localparam int ADDR_W    = 10;       // Serial address width
	localparam int DATA_W    = 6;        // Serial data word width
	localparam int REG_COUNT = 64;       // Register slots behind the decoder
	// Register indices
	localparam logic [5:0] A_MODE_LO   = 6'h00;
	localparam logic [5:0] A_MODE_HI   = 6'h01;
	localparam logic [5:0] A_GAIN_LO   = 6'h02;
	localparam logic [5:0] A_GAIN_HI   = 6'h03;
	localparam logic [5:0] A_BLACK_LO  = 6'h04;
	localparam logic [5:0] A_BLACK_HI  = 6'h05;
	localparam logic [5:0] A_CTRL      = 6'h06;
	localparam logic [5:0] A_COLOR0    = 6'h07;
	localparam logic [5:0] A_COLOR1    = 6'h08;
	localparam logic [5:0] A_COLOR2    = 6'h09;
	localparam logic [5:0] A_COLOR3    = 6'h0a;
	localparam logic [5:0] A_INIT_B    = 6'h10;
	localparam logic [5:0] A_SOFT_RST  = 6'h17;
	localparam logic [5:0] A_OUT_EN    = 6'h18;
	localparam logic [5:0] A_UPD_LO    = 6'h19;
	localparam logic [5:0] A_UPD_HI    = 6'h1a;
	localparam logic [5:0] A_FREEZE    = 6'h1b;
	localparam logic [5:0] A_READBACK  = 6'h1c;
	localparam logic [5:0] A_PHASE     = 6'h1d;
	localparam logic [5:0] A_PIXCLK_SRC = 6'h1e;
	localparam logic [5:0] A_HALVER    = 6'h1f;
	localparam logic [5:0] A_RESTORE   = 6'h20;
	localparam logic [5:0] A_FIELD     = 6'h21;
	localparam logic [5:0] A_RETIME12  = 6'h22;
	localparam logic [5:0] A_RETIME34  = 6'h23;
	localparam logic [5:0] A_SYNC_EN   = 6'h24;
	localparam logic [5:0] A_SYNC_POL  = 6'h25;
	localparam logic [5:0] A_SYNC_HOLD = 6'h26;
	localparam logic [5:0] A_LF_SEL    = 6'h27;
	localparam logic [5:0] A_CB_SEL    = 6'h28;
	localparam logic [5:0] A_TG_RUN    = 6'h29;
	localparam logic [5:0] A_FTRANS    = 6'h2a;
	localparam logic [5:0] A_INIT_A    = 6'h2b;
	localparam logic [5:0] A_SHARED    = 6'h31;
	localparam logic [5:0] A_DELAY     = 6'h32;
	localparam logic [5:0] A_OSC       = 6'h33;
	// Values after reset that are not zero, plus RST_ZERO
	localparam logic [5:0] RST_MODE_LO  = 6'h10;
	localparam logic [5:0] RST_GAIN_LO  = 6'h05;
	localparam logic [5:0] RST_GAIN_HI  = 6'h01;
	localparam logic [5:0] RST_BLACK_HI = 6'h02;
	localparam logic [5:0] RST_FIELD    = 6'h01;
	localparam logic [5:0] RST_SHARED   = 6'h01;
	localparam logic [5:0] RST_DELAY    = 6'h02;
	localparam logic [5:0] RST_OSC      = 6'h01;
	localparam logic [5:0] RST_ZERO     = 6'h00;
	localparam logic [3:0] ADDR_CNT     = 4'h9;   // Last address bit index
	localparam logic [3:0] DATA_CNT     = 4'h5;   // Last data bit index

	// Default contents of a register slot
	function automatic logic [5:0] regDefault(input logic [5:0] idx);
		case (idx)
			A_MODE_LO:  regDefault = RST_MODE_LO;
			A_GAIN_LO:  regDefault = RST_GAIN_LO;
			A_GAIN_HI:  regDefault = RST_GAIN_HI;
			A_BLACK_HI: regDefault = RST_BLACK_HI;
			A_FIELD:    regDefault = RST_FIELD;
			A_SHARED:   regDefault = RST_SHARED;
			A_DELAY:    regDefault = RST_DELAY;
			A_OSC:      regDefault = RST_OSC;
			default:    regDefault = RST_ZERO;
		endcase
	endfunction

	// Slots applied at the latch strobe rising edge
	function automatic logic isLatchClass(input logic [5:0] idx);
		case (idx)
			A_MODE_LO, A_MODE_HI, A_CTRL, A_SOFT_RST, A_READBACK, A_FIELD,
			A_RETIME12, A_RETIME34, A_SYNC_EN, A_SYNC_POL, A_SYNC_HOLD,
			A_TG_RUN, A_FTRANS, A_SHARED, A_DELAY, A_OSC, A_FREEZE:
				isLatchClass = 1'b1;
			default:
				isLatchClass = 1'b0;
		endcase
	endfunction

	// Lower half of a double-wide register
	function automatic logic isPairLow(input logic [5:0] idx);
		isPairLow = (idx == A_MODE_LO) || (idx == A_GAIN_LO) ||
			(idx == A_BLACK_LO) || (idx == A_UPD_LO);
	endfunction
endpackage

// ### ccd_afe_tg_control_registers_sva.sv
`timescale 1ns/1ps
// Port checks for the control register bank
module ccd_afe_tg_control_registers_sva (
	input wire logic       clk_sys,
	input wire logic       rst_b,
	input wire logic       clkEn,
	input wire logic       serial_latch_strobe,
	input wire logic       line_sync_pulse,
	input wire logic       black_level_clamp_pulse,
	input wire logic       output_blanking,
	input wire logic       dummy_clamp_pulse,
	input wire logic [7:0] afe_operation_mode,
	input wire logic [9:0] vga_gain,
	input wire logic [7:0] black_level,
	input wire logic       tgCoreReset_b,
	input wire logic [1:0] output_data_delay,
	input wire logic       oscillator_run,
	input wire logic       internalClockTick,
	input wire logic       sharedClampBlankPin,
	input wire logic       dummyClampOut,
	input wire logic       sgLineUpdate
);
	logic       latchLast;  // Strobe pin one clock back
	logic       lineLast;   // Line sync pin one clock back
	logic [3:0] sinceLatch; // Clocks since strobe rise, saturating
	logic [3:0] sinceLine;  // Clocks since line sync fall, saturating
	wire logic  latchRise = serial_latch_strobe & ~latchLast;
	wire logic  lineFall  = ~line_sync_pulse & lineLast;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	// Distance counters; start saturated so nothing looks recent after reset
	always_ff @(posedge clk_sys or negedge rst_b)
		if (!rst_b)
		begin
			latchLast  <= 1'b1;
			lineLast   <= 1'b1;
			sinceLatch <= 4'hf;
			sinceLine  <= 4'hf;
		end
		else if (clkEn)
		begin
			latchLast  <= serial_latch_strobe;
			lineLast   <= line_sync_pulse;
			sinceLatch <= latchRise ? 4'h0 : ((sinceLatch == 4'hf) ? sinceLatch : sinceLatch + 4'h1);
			sinceLine  <= lineFall ? 4'h0 : ((sinceLine == 4'hf) ? sinceLine : sinceLine + 4'h1);
		end
	reset_defaults_a: assert property (
		$rose(rst_b) |-> afe_operation_mode == 8'h10 && vga_gain == 10'h045 && black_level == 8'h80
		&& output_data_delay == 2'h2 && oscillator_run && !tgCoreReset_b)
		else $error("register defaults missing after reset");
	latch_apply_a: assert property (
		$changed(output_data_delay) || $changed(oscillator_run) || $changed(tgCoreReset_b)
		|| $changed(afe_operation_mode) |-> sinceLatch <= 4'h8)
		else $error("strobe-class output moved without a strobe rise");
	sync_apply_a: assert property (
		$changed(vga_gain) || $changed(black_level) |-> sinceLine <= 4'h8 || sinceLatch <= 4'h8)
		else $error("sync-class output moved away from a line sync");
	sg_pulse_a: assert property (sgLineUpdate |=> !sgLineUpdate)
		else $error("gate-line apply pulse longer than one clock");
	sg_cause_a: assert property (sgLineUpdate |-> sinceLine <= 4'h8)
		else $error("gate-line apply pulse without a line sync");
	dummy_follow_a: assert property (
		dummyClampOut |-> $past(black_level_clamp_pulse) || $past(dummy_clamp_pulse))
		else $error("dummy clamp high without a clamp source");
	clamp_blank_a: assert property (
		sharedClampBlankPin |-> $past(black_level_clamp_pulse) || $past(output_blanking))
		else $error("shared clamp pin high without a source");
	tick_toggle_a: assert property (!internalClockTick |=> internalClockTick)
		else $error("internal tick low for two clocks");
endmodule // ccd_afe_tg_control_registers_sva

bind ccd_afe_tg_control_registers ccd_afe_tg_control_registers_sva u_sva (
	.clk_sys, .rst_b, .clkEn, .serial_latch_strobe, .line_sync_pulse, .black_level_clamp_pulse,
	.output_blanking, .dummy_clamp_pulse, .afe_operation_mode, .vga_gain, .black_level,
	.tgCoreReset_b, .output_data_delay, .oscillator_run, .internalClockTick,
	.sharedClampBlankPin, .dummyClampOut, .sgLineUpdate
);

// ### serial_host_model.sv
`timescale 1ns/1ps
// Host side of the three-wire write link
module serial_host_model (
	input  wire logic clk_sys,
	output logic      serialClock,
	output logic      serialDataIn,
	output logic      serial_latch_strobe
);
	// Idle: strobe high, link clock parked low
	initial
	begin
		serialClock         = 1'b0;
		serialDataIn        = 1'b0;
		serial_latch_strobe = 1'b1;
	end
	// Four clocks per phase, above the three-clock minimum
	task automatic tick(input logic b);
		serialDataIn = b;
		repeat (4) @(negedge clk_sys);
		serialClock = 1'b1;
		repeat (4) @(negedge clk_sys);
		serialClock = 1'b0;
	endtask
	// Address, then nBits data bits; later words land on the next address
	task automatic writeReg(input logic [9:0] addr, input logic [17:0] data, input int nBits);
		@(negedge clk_sys);
		serial_latch_strobe = 1'b0;
		for (int i = 0; i < 10; i++)
			tick(addr[i]);
		for (int i = 0; i < nBits; i++)
			tick(data[i]);
		repeat (4) @(negedge clk_sys);
		serial_latch_strobe = 1'b1;
		// Released line must not keep showing the last bit
		serialDataIn = ~serialDataIn;
	endtask
endmodule // serial_host_model

// ### tb_ccd_afe_tg_control_registers.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb_ccd_afe_tg_control_registers;
	typedef struct { int sel; logic [15:0] val; } note_t;
	logic        clk_sys, rst_b, clkEn, serialClock, serialDataIn, serial_latch_strobe;
	logic        vertical_drive_pulse, line_sync_pulse, sensor_gate_pulse, extSyncIn;
	logic        master_clock_input, phaseClock, line_indicator, black_level_clamp_pulse;
	logic        output_blanking, dummy_clamp_pulse, horizontal_blanking, hClock1, hClock3;
	logic        serialDataOut, serialDataOe, input_restore_disable, tgCoreReset_b;
	logic        frame_transfer_select, oscillator_run, internalClockTick, pixel_data_clock;
	logic        sharedLineFieldPin, sharedClampBlankPin, dummyClampOut, blanking12;
	logic        blanking34, clocksSuspended, sgLineUpdate;
	logic [7:0]  afe_operation_mode, black_level;
	logic [9:0]  vga_gain, g, g2;
	logic [5:0]  afe_control_bits, color0Gain, color1Gain, color2Gain, color3Gain;
	logic [5:0]  output_phase_select;
	logic [1:0]  output_data_delay;
	logic [31:0] rnd;         // Raw random word
	int          seed = 32'h0000_47c9;
	int          err_count = 0;
	int          checked = 0;
	note_t       notes[$];    // Expected results, oldest first
	note_t       e;
	ccd_afe_tg_control_registers dut (.clk_sys, .rst_b, .clkEn, .serialClock, .serialDataIn,
		.serial_latch_strobe, .vertical_drive_pulse, .line_sync_pulse, .sensor_gate_pulse,
		.extSyncIn, .master_clock_input, .phaseClock, .line_indicator, .black_level_clamp_pulse,
		.output_blanking, .dummy_clamp_pulse, .horizontal_blanking, .hClock1, .hClock3,
		.serialDataOut, .serialDataOe, .afe_operation_mode, .vga_gain, .black_level,
		.afe_control_bits, .color0Gain, .color1Gain, .color2Gain, .color3Gain,
		.output_phase_select, .input_restore_disable, .tgCoreReset_b, .frame_transfer_select,
		.output_data_delay, .oscillator_run, .internalClockTick, .pixel_data_clock,
		.sharedLineFieldPin, .sharedClampBlankPin, .dummyClampOut, .blanking12, .blanking34,
		.clocksSuspended, .sgLineUpdate);
	serial_host_model host (.clk_sys, .serialClock, .serialDataIn, .serial_latch_strobe);
	// 10 MHz system clock
	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	// Selected output, widened for one comparison path
	function automatic logic [15:0] obs(input int s);
		case (s)
			0: obs = {8'h00, afe_operation_mode};
			1: obs = {6'h00, vga_gain};
			2: obs = {8'h00, black_level};
			3: obs = {14'h0000, output_data_delay};
			4: obs = {15'h0000, oscillator_run};
			5: obs = {15'h0000, tgCoreReset_b};
			6: obs = {15'h0000, pixel_data_clock};
			7: obs = {15'h0000, dummyClampOut};
			8: obs = {15'h0000, sharedClampBlankPin};
			default: obs = {15'h0000, blanking12};
		endcase
	endfunction
	task automatic ex(input int s, input logic [15:0] v);
		notes.push_back('{s, v});
	endtask
	// Apply latency is a few clocks; eight is ample
	task automatic settle();
		repeat (8) @(negedge clk_sys);
	endtask
	// Field sync, then one line with the sensor gate armed
	task automatic frame();
		vertical_drive_pulse = 1'b0;
		repeat (6) @(negedge clk_sys);
		vertical_drive_pulse = 1'b1;
		sensor_gate_pulse = 1'b1;
		repeat (6) @(negedge clk_sys);
		line_sync_pulse = 1'b0;
		sensor_gate_pulse = 1'b0;
		repeat (6) @(negedge clk_sys);
		line_sync_pulse = 1'b1;
		settle();
	endtask
	// Defaults on mode, gain, black level, delay, oscillator run and core reset; gated outputs held low
	task automatic checkDefaults();
		ex(0, 16'h0010);
		ex(1, 16'h0045);
		ex(2, 16'h0080);
		ex(3, 16'h0002);
		ex(4, 16'h0001);
		ex(5, 16'h0000);
		repeat (8)
		begin
			@(negedge clk_sys);
			for (int s = 6; s < 10; s++)
				ex(s, 16'h0000);
		end
	endtask
	task automatic complete_run();
		$display("Mismatches %0d, comparisons %0d", err_count, checked);
		if (err_count == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Level inputs take fresh random values every cycle
	always @(negedge clk_sys)
	begin
		rnd = $random(seed);
		{phaseClock, line_indicator, black_level_clamp_pulse, output_blanking, dummy_clamp_pulse,
			horizontal_blanking, hClock1, hClock3, master_clock_input, extSyncIn} <= rnd[9:0];
	end
	// Compare noted expectations against the outputs, oldest first
	always @(negedge clk_sys)
		while (notes.size() > 0)
		begin
			e = notes.pop_front();
			`CHK(obs(e.sel), e.val)
		end
	// Hang guard, far above the expected run length
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		err_count++;
		complete_run();
	end
	// Main sequence
	initial
	begin
		{rst_b, phaseClock, line_indicator, black_level_clamp_pulse, output_blanking} = 5'h00;
		{dummy_clamp_pulse, horizontal_blanking, hClock1, hClock3, master_clock_input} = 5'h00;
		{clkEn, vertical_drive_pulse, line_sync_pulse, sensor_gate_pulse, extSyncIn} = 5'h1c;
		repeat (16) @(posedge clk_sys);
		@(negedge clk_sys) rst_b = 1'b1;
		checkDefaults();
		host.writeReg(10'h010, 18'h0_0004, 6);
		host.writeReg(10'h02b, 18'h0_0035, 6);
		host.writeReg(10'h032, 18'h0_0003, 12);
		settle();
		ex(3, 16'h0003);
		ex(4, 16'h0000);
		host.writeReg(10'h029, 18'h0_0001, 6);
		host.writeReg(10'h032, 18'h0_0001, 4);
		settle();
		ex(5, 16'h0001);
		ex(3, 16'h0003);
		rnd = $random(seed);
		g = rnd[9:0];
		g2 = ~g;
		host.writeReg(10'h002, {6'h00, 2'h0, g[9:6], g[5:0]}, 12);
		settle();
		ex(1, 16'h0045);
		frame();
		ex(1, {6'h00, g});
		host.writeReg(10'h01b, 18'h0_0001, 6);
		host.writeReg(10'h002, {6'h00, 2'h0, g2[9:6], g2[5:0]}, 12);
		frame();
		ex(1, {6'h00, g});
		host.writeReg(10'h01b, 18'h0_0000, 6);
		host.writeReg(10'h002, {6'h00, 2'h0, g2[9:6], g2[5:0]}, 12);
		host.writeReg(10'h018, 18'h0_0001, 6);
		host.writeReg(10'h01f, 18'h0_0001, 6);
		frame();
		ex(1, {6'h00, g2});
		// Enabled outputs follow their default sources one clock later
		repeat (40)
		begin
			@(posedge clk_sys);
			ex(6, {15'h0000, phaseClock});
			ex(7, {15'h0000, black_level_clamp_pulse});
			ex(8, {15'h0000, black_level_clamp_pulse});
			ex(9, {15'h0000, horizontal_blanking});
		end
		host.writeReg(10'h017, 18'h0_0001, 6);
		settle();
		checkDefaults();
		settle();
		complete_run();
	end
endmodule // tb_ccd_afe_tg_control_registers
